// *** afpm_fault_mgr.v ***
// Fault protection manager of the speaker amplifier, with its APB registers.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "afpm_consts.vh"
module afpm_fault_mgr #(
  parameter [`AFPM_CNT_W-1:0] FAULT_TMO_CYC =
    `AFPM_FAULT_TMO_US * `AFPM_CLK_MHZ,
  parameter [`AFPM_CNT_W-1:0] DC_CYC =
    `AFPM_DC_TIME_MS * `AFPM_US_PER_MS * `AFPM_CLK_MHZ
) (
  // Clock and reset
  input  wire                    pclk,
  input  wire                    presetn,
  // APB slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`AFPM_ADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  // Shutdown pin
  input  wire                    amp_shutdown_n,
  // Analog condition indications
  input  wire                    ovr_volt_ind,
  input  wire                    undr_volt_ind,
  input  wire                    ovr_curr_ind,
  input  wire                    ovr_temp_ind,
  input  wire                    temp_below_hyst,
  // Clock monitor indications
  input  wire                    clk_ratio_bad,
  input  wire                    clk_rate_bad,
  input  wire                    clk_stopped,
  // Output duty indications, one bit per channel
  input  wire [1:0]              duty_high_pos,
  input  wire [1:0]              duty_high_neg,
  // Open-drain fault line
  output wire                    fault_n_out,
  output reg                     fault_n_oe,
  // Output stage control
  output reg                     out_stage_en
);

  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_LATCH = 2'b01;
  localparam [1:0] ST_ARMED = 2'b10;
  localparam [1:0] ST_WAIT  = 2'b11;

  // Synchronised inputs.
  wire [`AFPM_SYNC_W-1:0] raw_in;
  wire [`AFPM_SYNC_W-1:0] syn;
  wire                    dc_det;

  assign raw_in = {1'b0,
                   duty_high_neg[0],
                   duty_high_pos[0],
                   clk_stopped,
                   clk_rate_bad,
                   clk_ratio_bad,
                   temp_below_hyst,
                   ovr_temp_ind,
                   ovr_curr_ind,
                   undr_volt_ind,
                   ovr_volt_ind,
                   amp_shutdown_n};

  // The second channel of duty indications gets its own pair of synchronisers.
  wire [1:0] syn_ch1;

  afpm_sync #(
    .WIDTH     (`AFPM_SYNC_W),
    .RESET_VAL (12'h021)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  afpm_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h0)
  ) u_sync_ch1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({duty_high_neg[1], duty_high_pos[1]}),
    .sync_out (syn_ch1)
  );

  afpm_dc_det #(
    .DC_CYC (DC_CYC)
  ) u_dc_det (
    .pclk     (pclk),
    .presetn  (presetn),
    .duty_pos ({syn_ch1[0], syn[`AFPM_IN_DC_POS_LO]}),
    .duty_neg ({syn_ch1[1], syn[`AFPM_IN_DC_NEG_LO]}),
    .dc_det   (dc_det)
  );

  // Condition decode.
  wire pin_sd_n   = syn[`AFPM_IN_SD];
  wire ovr_volt   = syn[`AFPM_IN_OVR_VOLT];
  wire undr_volt  = syn[`AFPM_IN_UNDR_VOLT];
  wire ovr_curr   = syn[`AFPM_IN_OVR_CURR];
  wire hot        = syn[`AFPM_IN_OVR_TEMP];
  wire cool       = syn[`AFPM_IN_TEMP_HYST];
  wire clk_err    = syn[`AFPM_IN_CLK_RATIO] |
                    syn[`AFPM_IN_CLK_RATE]  |
                    syn[`AFPM_IN_CLK_STOP];
  // Overtemperature stays present until the die drops below hysteresis.
  wire ovr_temp   = hot | ~cool;
  wire latch_cond = ovr_curr | dc_det | hot;
  wire still_bad  = ovr_curr | dc_det | ovr_temp;
  wire nonlatch   = ovr_volt | undr_volt | clk_err;

  // Control register.
  reg  sd_bit;
  wire sd_n = pin_sd_n & sd_bit;
  reg  sd_n_q;
  wire sd_fall = sd_n_q & ~sd_n;
  wire sd_rise = ~sd_n_q & sd_n;

  // Latch state machine and time-out counter.
  reg  [1:0]             state;
  reg  [1:0]             next_state;
  reg  [`AFPM_CNT_W-1:0] tmo_cnt;
  reg                    tmo_restart;
  wire                   tmo_done = (tmo_cnt >= FAULT_TMO_CYC);

  always @* begin
    next_state  = state;
    tmo_restart = 1'b0;
    case (state)
      ST_RUN: begin
        if (latch_cond) begin
          next_state  = ST_LATCH;
          tmo_restart = 1'b1;
        end
      end
      ST_LATCH: begin
        if (sd_fall || !sd_n) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (sd_rise) begin
          if (still_bad) begin
            next_state  = ST_LATCH;
            tmo_restart = 1'b1;
          end else if (tmo_done) begin
            next_state = ST_RUN;
          end else begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (latch_cond) begin
          next_state  = ST_LATCH;
          tmo_restart = 1'b1;
        end else if (!sd_n) begin
          next_state = ST_ARMED;
        end else if (tmo_done) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_LATCH;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= ST_RUN;
      sd_n_q <= 1'b1;
    end else begin
      state  <= next_state;
      sd_n_q <= sd_n;
    end
  end

  // Time-out runs from fault entry so a fault line tied to shutdown can release.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt <= {`AFPM_CNT_W{1'b0}};
    end else if (tmo_restart) begin
      tmo_cnt <= {`AFPM_CNT_W{1'b0}};
    end else if (!tmo_done && state != ST_RUN) begin
      tmo_cnt <= tmo_cnt + {{(`AFPM_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Latched status flags; a new event wins over the clear at resume.
  reg  oc_flag;
  reg  dc_flag;
  reg  ot_flag;
  wire resume = (state != ST_RUN) && (next_state == ST_RUN);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_flag <= 1'b0;
      dc_flag <= 1'b0;
      ot_flag <= 1'b0;
    end else begin
      oc_flag <= (oc_flag & ~resume) | ovr_curr;
      dc_flag <= (dc_flag & ~resume) | dc_det;
      ot_flag <= (ot_flag & ~resume) | hot;
    end
  end

  // Fault line: the latched part releases once the time-out is done, the latching conditions have cleared and shutdown has fallen,
  // which lets a fault line wired to shutdown recover on its own.
  wire latch_hold = (state == ST_LATCH) ||
                    (state == ST_ARMED && !(tmo_done && !still_bad)) ||
                    (state == ST_WAIT);
  // From the waiting state the latched part drops on the resume edge itself, so the line never overlaps an enabled stage.
  wire next_fault = (latch_hold && (next_state != ST_RUN)) | clk_err;

  assign fault_n_out = 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_n_oe   <= 1'b0;
      out_stage_en <= 1'b0;
    end else begin
      fault_n_oe   <= next_fault;
      // Non-latching errors gate the stage directly and so recover at once.
      out_stage_en <= (next_state == ST_RUN) && !latch_cond &&
                      !nonlatch && sd_n;
    end
  end

  // APB slave: zero wait states, error on an unmapped address.
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  // Full-word match; an address between two registers selects nothing.
  function addr_hit;
    input [`AFPM_ADDR_W-1:0] addr;
    input [`AFPM_ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  wire is_ctrl = addr_hit(paddr, `AFPM_OFS_CTRL);
  wire is_stat = addr_hit(paddr, `AFPM_OFS_STATUS);
  wire mapped  = is_ctrl | is_stat;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Status word assembled field by field, so the layout lives in the constants only.
  reg  [31:0] status_word;
  always @* begin
    status_word                                      = 32'h0000_0000;
    status_word[`AFPM_ST_OVR_VOLT]                   = ovr_volt;
    status_word[`AFPM_ST_UNDR_VOLT]                  = undr_volt;
    status_word[`AFPM_ST_CLK]                        = clk_err;
    status_word[`AFPM_ST_OVR_CURR]                   = oc_flag;
    status_word[`AFPM_ST_DC_OFF]                     = dc_flag;
    status_word[`AFPM_ST_OVR_TEMP]                   = ot_flag;
    status_word[`AFPM_ST_STATE_HI:`AFPM_ST_STATE_LO] = state;
    status_word[`AFPM_ST_OUT_EN]                     = out_stage_en;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_bit <= `AFPM_CTRL_RESET;
    end else if (access && pwrite && is_ctrl) begin
      sd_bit <= pwdata[`AFPM_CTRL_SD_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (is_ctrl) begin
        prdata <= {31'h0, sd_bit};
      end else if (is_stat) begin
        prdata <= status_word;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // afpm_fault_mgr

// *** afpm_consts.vh ***
// Constants shared by the amplifier fault protection manager files.
`ifndef AFPM_CONSTS_VH
`define AFPM_CONSTS_VH

// Core clock rate.
`define AFPM_CLK_MHZ          100
// Fault time-out length in microseconds; the value is a plain default.
`define AFPM_FAULT_TMO_US     1000
// DC detect qualification time in milliseconds.
`define AFPM_DC_TIME_MS       420
`define AFPM_US_PER_MS        1000
`define AFPM_CNT_W            32

// APB register byte offsets.
`define AFPM_ADDR_W           8
`define AFPM_OFS_CTRL         8'h00
`define AFPM_OFS_STATUS       8'h04

// Control register fields.
`define AFPM_CTRL_SD_BIT      0
`define AFPM_CTRL_RESET       1'h1

// Status register fields.
`define AFPM_ST_OVR_VOLT      0
`define AFPM_ST_UNDR_VOLT     1
`define AFPM_ST_CLK           2
`define AFPM_ST_OVR_CURR      3
`define AFPM_ST_DC_OFF        4
`define AFPM_ST_OVR_TEMP      5
`define AFPM_ST_STATE_LO      8
`define AFPM_ST_STATE_HI      9
`define AFPM_ST_OUT_EN        12

// Synchronised input vector layout.
`define AFPM_SYNC_W           12
`define AFPM_IN_SD            0
`define AFPM_IN_OVR_VOLT      1
`define AFPM_IN_UNDR_VOLT     2
`define AFPM_IN_OVR_CURR      3
`define AFPM_IN_OVR_TEMP      4
`define AFPM_IN_TEMP_HYST     5
`define AFPM_IN_CLK_RATIO     6
`define AFPM_IN_CLK_RATE      7
`define AFPM_IN_CLK_STOP      8
`define AFPM_IN_DC_POS_LO     9
`define AFPM_IN_DC_NEG_LO     10
`define AFPM_IN_SPARE         11

`endif

// *** afpm_sync.v ***
// Two-flop synchronisers for the asynchronous condition inputs.
`timescale 1ns/100ps
module afpm_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta   <= RESET_VAL[i];
          stable <= RESET_VAL[i];
        end else begin
          meta   <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // afpm_sync

// *** afpm_dc_det.v ***
// DC offset detector: one qualification timer per output channel.
`timescale 1ns/100ps
`include "afpm_consts.vh"
module afpm_dc_det #(
  parameter [`AFPM_CNT_W-1:0] DC_CYC = 32'd42000000
) (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Per-channel duty indications, already synchronised
  input  wire [1:0] duty_pos,
  input  wire [1:0] duty_neg,
  // Detection result
  output wire       dc_det
);

  wire [1:0] hit;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg [`AFPM_CNT_W-1:0] cnt;
      reg                   last_pos;
      reg                   det;
      wire                  one_pol = duty_pos[ch] ^ duty_neg[ch];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt      <= {`AFPM_CNT_W{1'b0}};
          last_pos <= 1'b0;
          det      <= 1'b0;
        end else begin
          last_pos <= duty_pos[ch];
          // A polarity change restarts the timer, so only a single polarity qualifies.
          if (!one_pol || (duty_pos[ch] != last_pos)) begin
            cnt <= {`AFPM_CNT_W{1'b0}};
            det <= 1'b0;
          end else if (cnt < DC_CYC) begin
            cnt <= cnt + {{(`AFPM_CNT_W-1){1'b0}}, 1'b1};
          end else begin
            det <= 1'b1;
          end
        end
      end
      assign hit[ch] = det;
    end
  endgenerate

  assign dc_det = |hit;

endmodule // afpm_dc_det

// *** afpm_monitor.sv ***
// Port checker of the fault protection manager.
`timescale 1ns/100ps
module afpm_monitor #(
  parameter [31:0] FAULT_TMO_CYC = 32'h14
) (
  // Clock and reset
  input wire       pclk,
  input wire       presetn,
  // Conditions
  input wire       amp_shutdown_n,
  input wire       ovr_volt_ind,
  input wire       undr_volt_ind,
  input wire       ovr_curr_ind,
  input wire       ovr_temp_ind,
  input wire       temp_below_hyst,
  input wire       clk_ratio_bad,
  input wire       clk_rate_bad,
  input wire       clk_stopped,
  input wire [1:0] duty_high_pos,
  input wire [1:0] duty_high_neg,
  // Outputs
  input wire       fault_n_out,
  input wire       fault_n_oe,
  input wire       out_stage_en
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire clk_bad = clk_ratio_bad | clk_rate_bad | clk_stopped;
  wire cause = ovr_curr_ind | ovr_temp_ind | !temp_below_hyst | clk_bad | (|duty_high_pos) | (|duty_high_neg);
  reg [31:0] oe_cnt;
  reg        lat_seen;
  // Counts how long the line has been pulled in the current episode.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cnt   <= 32'h0;
      lat_seen <= 1'h0;
    end else begin
      oe_cnt   <= fault_n_oe ? oe_cnt + 32'h1 : 32'h0;
      lat_seen <= fault_n_oe & (lat_seen | ovr_curr_ind | ovr_temp_ind);
    end
  end
  // A latching fault reaches the line one edge after the state change, a clock error does not.
  a_curr_pulls_line: assert property (ovr_curr_ind [*4] |=> fault_n_oe)
    else $error("overcurrent did not pull the line");
  a_clk_pulls_line: assert property (clk_bad [*3] |=> fault_n_oe)
    else $error("clock error did not pull the line");
  a_supply_stage_off: assert property ((ovr_volt_ind | undr_volt_ind) [*3] |=> !out_stage_en)
    else $error("stage enabled during supply error");
  a_rise_has_cause: assert property ($rose(fault_n_oe) |-> $past(cause, 3))
    else $error("line pulled without a pulling cause");
  a_od_drive_low: assert property (fault_n_oe |-> !fault_n_out)
    else $error("open drain drives high");
  a_fault_stage_off: assert property (fault_n_oe |-> !out_stage_en)
    else $error("stage enabled while line pulled");
  a_sd_stage_off: assert property ((!amp_shutdown_n) [*3] |=> !out_stage_en)
    else $error("stage enabled in shutdown");
  a_tmo_line_hold: assert property ($fell(fault_n_oe) && lat_seen |-> oe_cnt >= FAULT_TMO_CYC - 32'h1)
    else $error("latched fault released before time-out");
  c_latched_release: cover property ($fell(fault_n_oe) && lat_seen);
  c_clk_fault: cover property (clk_bad ##1 fault_n_oe);
  c_stage_resume: cover property ($rose(out_stage_en));
endmodule // afpm_monitor

bind afpm_fault_mgr afpm_monitor #(.FAULT_TMO_CYC(FAULT_TMO_CYC)) u_afpm_monitor (
  .pclk(pclk), .presetn(presetn), .amp_shutdown_n(amp_shutdown_n), .ovr_volt_ind(ovr_volt_ind),
  .undr_volt_ind(undr_volt_ind), .ovr_curr_ind(ovr_curr_ind), .ovr_temp_ind(ovr_temp_ind),
  .temp_below_hyst(temp_below_hyst), .clk_ratio_bad(clk_ratio_bad), .clk_rate_bad(clk_rate_bad),
  .clk_stopped(clk_stopped), .duty_high_pos(duty_high_pos), .duty_high_neg(duty_high_neg),
  .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe), .out_stage_en(out_stage_en));

// *** afpm_sys_ctrl.sv ***
// Behavioural system controller on the shutdown and fault lines.
`timescale 1ns/100ps
module afpm_sys_ctrl (
  // Bench controls
  input  wire sd_req,
  input  wire tie,
  // Device fault pin
  input  wire fault_n_out,
  input  wire fault_n_oe,
  // Resolved lines
  output wire fault_n,
  output wire amp_shutdown_n
);
  // Only the pull-up sets the idle level; the device may only pull low.
  assign fault_n = fault_n_oe ? fault_n_out : 1'h1;
  // Tied mode turns a latched fault into an automatic toggle.
  assign amp_shutdown_n = tie ? fault_n : sd_req;
endmodule // afpm_sys_ctrl

// *** amp_fault_protection_manager_test.sv ***
// Self-checking bench of the fault protection manager.
`timescale 1ns/100ps
module amp_fault_protection_manager_test;
  reg         pclk = 1'h0;
  reg         presetn = 1'h0;
  reg         psel = 1'h0;
  reg         penable = 1'h0;
  reg         pwrite = 1'h0;
  reg  [7:0]  paddr = 8'h0;
  reg  [31:0] pwdata = 32'h0;
  reg         sd_req = 1'h1;
  reg         tie = 1'h0;
  reg         hyst = 1'h1;
  reg  [10:0] cnd = 11'h0;
  reg  [31:0] rd;
  reg         se;
  wire [31:0] prdata;
  wire        pready, pslverr, fault_n_out, fault_n_oe, out_stage_en, fault_n, amp_shutdown_n;
  integer     err_total = 0;
  integer     num_checks = 0;
  integer     k;

  afpm_fault_mgr #(.FAULT_TMO_CYC(32'h14), .DC_CYC(32'h10)) u_afpm_fault_mgr (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .amp_shutdown_n(amp_shutdown_n), .ovr_volt_ind(cnd[0]), .undr_volt_ind(cnd[1]),
    .ovr_curr_ind(cnd[2]), .ovr_temp_ind(cnd[3]), .temp_below_hyst(hyst), .clk_ratio_bad(cnd[4]),
    .clk_rate_bad(cnd[5]), .clk_stopped(cnd[6]), .duty_high_pos(cnd[8:7]), .duty_high_neg(cnd[10:9]),
    .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe), .out_stage_en(out_stage_en));
  afpm_sys_ctrl u_afpm_sys_ctrl (.sd_req(sd_req), .tie(tie), .fault_n_out(fault_n_out),
    .fault_n_oe(fault_n_oe), .fault_n(fault_n), .amp_shutdown_n(amp_shutdown_n));

  always #5 pclk = ~pclk;

  task results;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask

  task ck(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task wt(input integer n);
    begin
      repeat (n) @(negedge pclk);
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      i = 0;
      do begin
        @(posedge pclk);
        i = i + 1;
      end while (pready !== 1'h1 && i < 50);
      if (pready !== 1'h1) begin
        err_total = err_total + 1;
        results;
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task sck(input [31:0] m, input [31:0] e);
    begin
      apb(1'h0, 8'h04, 32'h0);
      ck(rd & m, e);
    end
  endtask

  task drv(input [10:0] v, input h);
    begin
      @(posedge pclk);
      cnd <= v;
      hyst <= h;
    end
  endtask

  task tog(input integer n);
    begin
      @(posedge pclk);
      sd_req <= 1'h0;
      wt(n);
      @(posedge pclk);
      sd_req <= 1'h1;
    end
  endtask

  // A cleared condition must still wait for toggle and time-out; with h low the
  // temperature sits between threshold and hysteresis during the first toggle.
  task latch(input [10:0] v, input [31:0] sb, input h, input bp);
    begin
      drv(v, h);
      wt(24);
      ck(fault_n, 1'h0);
      sck(32'h33f, sb | 32'h100);
      drv(h ? v : 11'h0, h);
      tog(2);
      wt(8);
      ck({fault_n, out_stage_en}, 2'h0);
      drv(11'h0, 1'h1);
      wt(30);
      ck({fault_n, out_stage_en}, 2'h0);
      if (bp) begin
        apb(1'h1, 8'h00, 32'h0);
        wt(3);
        apb(1'h1, 8'h00, 32'h1);
      end else tog(6);
      wt(8);
      ck({fault_n, out_stage_en}, 2'h3);
      sck(32'h33f, 32'h0);
    end
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_total = err_total + 1;
    results;
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    wt(6);
    apb(1'h0, 8'h00, 32'h0);
    ck(rd, 32'h1);
    apb(1'h0, 8'h08, 32'h0);
    ck(rd, 32'h0);
    ck(se, 1'h1);
    tog(5);
    wt(1);
    ck(out_stage_en, 1'h0);
    wt(5);
    ck(out_stage_en, 1'h1);
    for (k = 0; k < 7; k = k + 1) begin
      if (k != 2 && k != 3) begin
        drv(11'h1 << k, 1'h1);
        wt(6);
        ck({fault_n, out_stage_en}, {k < 2, 1'h0});
        sck(32'h7, k < 2 ? 32'h1 << k : 32'h4);
        drv(11'h0, 1'h1);
        wt(6);
        ck({fault_n, out_stage_en}, 2'h3);
      end
    end
    latch(11'h004, 32'h08, 1'h1, 1'h0);
    drv(11'h080, 1'h1);
    wt(10);
    ck(fault_n, 1'h1);
    latch(11'h080, 32'h10, 1'h1, 1'h1);
    latch(11'h400, 32'h10, 1'h1, 1'h0);
    latch(11'h008, 32'h20, 1'h0, 1'h0);
    // A toggle well before the time-out ends must park in the waiting state.
    drv(11'h004, 1'h1);
    wt(6);
    drv(11'h0, 1'h1);
    tog(2);
    wt(10);
    ck({fault_n, out_stage_en}, 2'h0);
    sck(32'h300, 32'h300);
    wt(7);
    ck({fault_n, out_stage_en}, 2'h3);
    sck(32'h33f, 32'h0);
    @(posedge pclk);
    tie <= 1'h1;
    drv(11'h004, 1'h1);
    wt(6);
    drv(11'h0, 1'h1);
    k = 0;
    while (out_stage_en !== 1'h1 && k < 100) begin
      wt(1);
      k = k + 1;
    end
    if (k == 100) begin
      err_total = err_total + 1;
      results;
    end
    ck({fault_n, k > 10}, 2'h3);
    results;
  end
endmodule // amp_fault_protection_manager_test
